/* core/acl_pkg.sv */
// Constants, register map and field layout of the analogue channel limit, fault and scaling block
package acl_pkg;

  // ===========================================================================
  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] ACL_OFS_CTRL     = 8'h00;
  localparam logic [7:0] ACL_OFS_USER_LO  = 8'h04;
  localparam logic [7:0] ACL_OFS_SCALE_LO = 8'h08;
  localparam logic [7:0] ACL_OFS_SCALE_HI = 8'h0c;
  localparam logic [7:0] ACL_OFS_FAULT    = 8'h10;
  localparam logic [7:0] ACL_OFS_IDLE     = 8'h14;
  localparam logic [7:0] ACL_OFS_SETVAL   = 8'h18;
  localparam logic [7:0] ACL_OFS_STATUS   = 8'h1c;
  localparam logic [7:0] ACL_OFS_MASK     = 8'h20;
  localparam logic [7:0] ACL_OFS_OUT      = 8'h24;

  // ===========================================================================
  // Control register fields
  localparam int ACL_CTRL_W       = 10;
  localparam int ACL_CB_LO_CHK    = 0;
  localparam int ACL_CB_FAULT_SUB = 1;
  localparam int ACL_CB_IDLE_SUB  = 2;
  localparam int ACL_CB_FMT_LSB   = 3;
  localparam int ACL_CB_RNG_LSB   = 5;
  localparam int ACL_CB_PRIO_SW   = 8;
  localparam int ACL_CB_SC_CHK    = 9;
  localparam logic [9:0] ACL_CTRL_RST = 10'h000;

  typedef enum logic [1:0] {
    ACL_FMT_OFFSET = 2'h0,
    ACL_FMT_SIGNMAG = 2'h1,
    ACL_FMT_TWOS   = 2'h2,
    ACL_FMT_SCALED = 2'h3
  } acl_fmt_e;

  typedef enum logic [2:0] {
    ACL_RNG_0_10V  = 3'h0,
    ACL_RNG_0_5V   = 3'h1,
    ACL_RNG_1_5V   = 3'h2,
    ACL_RNG_0_20MA = 3'h3,
    ACL_RNG_4_20MA = 3'h4
  } acl_rng_e;

  // ===========================================================================
  // Status and mask bits
  localparam int ACL_ST_W      = 3;
  localparam int ACL_SB_USR_LO = 0;
  localparam int ACL_SB_SC_LO  = 1;
  localparam int ACL_SB_CLAMP  = 2;

  // ===========================================================================
  // Reset values of set values (scale limits in two's complement)
  localparam logic [15:0] ACL_USER_LO_RST  = 16'h0000;
  localparam logic [15:0] ACL_SCALE_LO_RST = 16'h0000;
  localparam logic [15:0] ACL_SCALE_HI_RST = 16'h03e8;
  localparam logic [15:0] ACL_VAL_RST      = 16'h0000;

  // ===========================================================================
  // Scale limit bounds
  localparam logic signed [17:0] ACL_SLO_MIN = -18'sd32767;
  localparam logic signed [17:0] ACL_SLO_MAX = 18'sd32766;
  localparam logic signed [17:0] ACL_SHI_MIN = -18'sd32766;
  localparam logic signed [17:0] ACL_SHI_MAX = 18'sd32767;

  // ===========================================================================
  // Ranges in hundredths of a volt or milliamp: nominal ends and settable span
  localparam logic signed [17:0] ACL_NOM_LO_0_10V  = 18'sd0;
  localparam logic signed [17:0] ACL_NOM_HI_0_10V  = 18'sd1000;
  localparam logic signed [17:0] ACL_SET_HI_0_10V  = 18'sd1050;
  localparam logic signed [17:0] ACL_NOM_LO_0_5V   = 18'sd0;
  localparam logic signed [17:0] ACL_NOM_HI_0_5V   = 18'sd500;
  localparam logic signed [17:0] ACL_SET_HI_0_5V   = 18'sd525;
  localparam logic signed [17:0] ACL_NOM_LO_1_5V   = 18'sd100;
  localparam logic signed [17:0] ACL_SET_LO_1_5V   = 18'sd75;
  localparam logic signed [17:0] ACL_NOM_LO_0_20MA = 18'sd0;
  localparam logic signed [17:0] ACL_NOM_HI_20MA   = 18'sd2000;
  localparam logic signed [17:0] ACL_SET_HI_20MA   = 18'sd2100;
  localparam logic signed [17:0] ACL_NOM_LO_4_20MA = 18'sd400;
  localparam logic signed [17:0] ACL_SET_LO_4_20MA = 18'sd300;
  localparam logic signed [17:0] ACL_SET_LO_ZERO   = 18'sd0;

endpackage

/* core/acl_channel.sv */
// Analogue channel value processing: limit checks, fault/idle substitution, scaling, Wishbone registers
//
// What this block does
// R01: Optional check flags an error when input or host set value falls below the user lower limit.
// R02: Scale limits bounded; scaled values map linearly onto the selected signal range.
// R03: Any scaled value from -32767 to 32767 may be used as the converted value.
// R04: On comm fault, drive user fault value if enabled, else hold last output.
// R05: While comm idles, drive user idle value if enabled, else hold last output.
// R06: Per-channel fault substitution only counts when system priority selects software control.
// R07: Non-scaled set values are volts or milliamps times 100 as integers.
// R08: Scaled 16-bit set values are sign-magnitude: bit 15 marks negative.
// R09: Host keeps set values inside the settable span of the selected range.
// R10: Out-of-span values are clamped so the driven output stays in range; a level held across a range change is not clamped to the new range.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module acl_channel
  import acl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              I_CLOCK,      // 200 MHz system clock
  input  wire logic              I_RST,        // Asynchronous reset, active high
  input  wire logic              I_WB_CYC,     // Wishbone cycle
  input  wire logic              I_WB_STB,     // Wishbone strobe
  input  wire logic              I_WB_WE,      // Wishbone write enable
  input  wire logic [ADDR_W-1:0] I_WB_ADR,     // Wishbone byte address
  input  wire logic [3:0]        I_WB_SEL,     // Wishbone byte enables
  input  wire logic [31:0]       I_WB_DAT,     // Wishbone write data
  input  wire logic              I_COMM_FAULT, // Host communication fault, level
  input  wire logic              I_COMM_IDLE,  // Host communication idling, level
  input  wire logic [15:0]       I_IN_VALUE,   // Measured channel value, host format
  output logic                   O_WB_ACK,     // Wishbone acknowledge
  output logic [31:0]            O_WB_DAT,     // Wishbone read data
  output logic                   O_IRQ,        // Interrupt, level
  output logic [15:0]            O_OUT_VALUE,  // Driven output in hundredths of V or mA
  output logic [1:0]             O_LIMIT_ERR   // Live errors: [0] user lower, [1] scale lower
);

  // ===========================================================================
  // State
  typedef struct packed {
    logic [ACL_CTRL_W-1:0] ctrl;
    logic [15:0]           user_lo;
    logic [15:0]           scale_lo;
    logic [15:0]           scale_hi;
    logic [15:0]           fault_val;
    logic [15:0]           idle_val;
    logic [15:0]           set_val;
    logic [ACL_ST_W-1:0]   status;
    logic [ACL_ST_W-1:0]   mask;
    logic [15:0]           out;
    logic [1:0]            err;
    logic                  ack;
    logic [31:0]           rdat;
    logic                  irq;
  } acl_state_s;

  acl_state_s st_reg;
  acl_state_s st_next;

  // ===========================================================================
  // Helpers
  // Sign-magnitude set value to signed; negative zero becomes zero
  function automatic logic signed [17:0] sm_decode(input logic [15:0] v);
    logic signed [17:0] mag;
    mag = signed'({3'b000, v[14:0]});
    return v[15] ? -mag : mag;
  endfunction

  // Set value as a comparable signed number in the current format
  function automatic logic signed [17:0] as_num(input logic [15:0] v, input logic scaled);
    return scaled ? sm_decode(v) : signed'({2'b00, v});
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = d[7:0];
    if (sel[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // ===========================================================================
  // Range decode
  acl_rng_e           rng;
  logic               scaled;
  logic signed [17:0] nom_lo;
  logic signed [17:0] nom_hi;
  logic signed [17:0] set_lo;
  logic signed [17:0] set_hi;

  // The settable span is wider than nominal; outputs are clamped to it, not to nominal
  always_comb begin
    rng    = acl_rng_e'(st_reg.ctrl[ACL_CB_RNG_LSB +: 3]);
    scaled = (st_reg.ctrl[ACL_CB_FMT_LSB +: 2] == ACL_FMT_SCALED);
    case (rng)
      ACL_RNG_0_10V: begin
        nom_lo = ACL_NOM_LO_0_10V;
        nom_hi = ACL_NOM_HI_0_10V;
        set_lo = ACL_SET_LO_ZERO;
        set_hi = ACL_SET_HI_0_10V;
      end
      ACL_RNG_0_5V: begin
        nom_lo = ACL_NOM_LO_0_5V;
        nom_hi = ACL_NOM_HI_0_5V;
        set_lo = ACL_SET_LO_ZERO;
        set_hi = ACL_SET_HI_0_5V;
      end
      ACL_RNG_1_5V: begin
        nom_lo = ACL_NOM_LO_1_5V;
        nom_hi = ACL_NOM_HI_0_5V;
        set_lo = ACL_SET_LO_1_5V;
        set_hi = ACL_SET_HI_0_5V;
      end
      ACL_RNG_0_20MA: begin
        nom_lo = ACL_NOM_LO_0_20MA;
        nom_hi = ACL_NOM_HI_20MA;
        set_lo = ACL_SET_LO_ZERO;
        set_hi = ACL_SET_HI_20MA;
      end
      ACL_RNG_4_20MA: begin
        nom_lo = ACL_NOM_LO_4_20MA;
        nom_hi = ACL_NOM_HI_20MA;
        set_lo = ACL_SET_LO_4_20MA;
        set_hi = ACL_SET_HI_20MA;
      end
      default: begin
        // Unused codes fall back to the widest voltage range
        nom_lo = ACL_NOM_LO_0_10V;
        nom_hi = ACL_NOM_HI_0_10V;
        set_lo = ACL_SET_LO_ZERO;
        set_hi = ACL_SET_HI_0_10V;
      end
    endcase
  end

  // ===========================================================================
  // Source selection and conversion
  logic               hold;
  logic [15:0]        src;
  logic               fault_sub;
  logic signed [17:0] slo;
  logic signed [17:0] shi;
  logic signed [31:0] num;
  logic signed [31:0] den;
  logic signed [31:0] raw;
  logic               under;
  logic               over;
  logic [15:0]        conv;

  always_comb begin
    fault_sub = st_reg.ctrl[ACL_CB_PRIO_SW] & st_reg.ctrl[ACL_CB_FAULT_SUB]; // see R06
    hold      = 1'b0;
    src       = st_reg.set_val;
    // Fault outranks idle; a hold keeps the register, so a range change made during
    // a hold leaves the old level standing until the link recovers
    if (I_COMM_FAULT) begin
      if (fault_sub) begin
        src = st_reg.fault_val; // see R04
      end else begin
        hold = 1'b1; // see R04
      end
    end else if (I_COMM_IDLE) begin
      if (st_reg.ctrl[ACL_CB_IDLE_SUB]) begin
        src = st_reg.idle_val; // see R05
      end else begin
        hold = 1'b1; // see R05
      end
    end
    slo = signed'({{2{st_reg.scale_lo[15]}}, st_reg.scale_lo});
    shi = signed'({{2{st_reg.scale_hi[15]}}, st_reg.scale_hi});
    // Linear map from the scale span onto the nominal range
    // The one-cycle divide is the long path at 200 MHz; pipeline it if timing falls short
    num = 32'(sm_decode(src) - slo) * 32'(nom_hi - nom_lo); // see R02, R03, R08
    den = 32'(shi - slo);
    if (!scaled) begin
      raw = 32'(signed'({2'b00, src})); // see R07
    end else if (den > 0) begin
      raw = 32'(nom_lo) + num / den; // see R02
    end else begin
      // Degenerate limits cannot divide; park at the range start
      raw = 32'(nom_lo);
    end
    under = raw < 32'(set_lo);
    over  = raw > 32'(set_hi);
    if (under) begin
      conv = set_lo[15:0]; // see R10
    end else if (over) begin
      conv = set_hi[15:0]; // see R10
    end else begin
      conv = raw[15:0];
    end
  end

  // ===========================================================================
  // Limit checks on the host output value and the measured input
  logic signed [17:0] lo_num;
  logic signed [17:0] set_num;
  logic signed [17:0] in_num;
  logic               usr_lo_err;
  logic               sc_lo_err;

  // Checks watch the host set value, not a substituted one, so a fault value
  // below the limit raises nothing while it is driven
  always_comb begin
    lo_num     = as_num(st_reg.user_lo, scaled);
    set_num    = as_num(st_reg.set_val, scaled);
    in_num     = as_num(I_IN_VALUE, scaled);
    usr_lo_err = st_reg.ctrl[ACL_CB_LO_CHK] & ((set_num < lo_num) | (in_num < lo_num)); // see R01
    sc_lo_err  = st_reg.ctrl[ACL_CB_SC_CHK] & scaled &
                 ((sm_decode(st_reg.set_val) < slo) |
                  (sm_decode(I_IN_VALUE) < slo)); // see R02
  end

  // ===========================================================================
  // Bus slave and next state
  logic                req;
  logic                wr;
  logic [ACL_ST_W-1:0] clr;
  logic [ACL_ST_W-1:0] evt;
  logic [31:0]         rd;
  logic [15:0]         wv;
  logic signed [17:0]  wv_s;
  logic                refused;

  // Ack is registered: each access takes two cycles, and the ack term in req
  // keeps a strobe held through the ack from being taken twice
  always_comb begin
    st_next = st_reg;
    req     = I_WB_CYC & I_WB_STB & ~st_reg.ack;
    wr      = req & I_WB_WE;
    clr     = '0;
    rd      = 32'h0000_0000;
    wv      = 16'h0000;
    wv_s    = 18'sd0;
    refused = 1'b0;
    st_next.ack = req;
    case (I_WB_ADR)
      ACL_OFS_CTRL: begin
        rd = {22'h000000, st_reg.ctrl};
        if (wr && I_WB_SEL[0]) st_next.ctrl[7:0] = I_WB_DAT[7:0];
        if (wr && I_WB_SEL[1]) st_next.ctrl[9:8] = I_WB_DAT[9:8];
      end
      ACL_OFS_USER_LO: begin
        rd = {16'h0000, st_reg.user_lo};
        if (wr) st_next.user_lo = wmerge(st_reg.user_lo, I_WB_DAT, I_WB_SEL);
      end
      ACL_OFS_SCALE_LO: begin
        rd   = {16'h0000, st_reg.scale_lo};
        wv   = wmerge(st_reg.scale_lo, I_WB_DAT, I_WB_SEL);
        wv_s = signed'({{2{wv[15]}}, wv});
        // Out-of-bounds limits are refused and flagged, never stored
        if (wr) begin
          if (wv_s >= ACL_SLO_MIN && wv_s <= ACL_SLO_MAX) begin
            st_next.scale_lo = wv; // see R02
          end else begin
            refused = 1'b1; // see R02
          end
        end
      end
      ACL_OFS_SCALE_HI: begin
        rd   = {16'h0000, st_reg.scale_hi};
        wv   = wmerge(st_reg.scale_hi, I_WB_DAT, I_WB_SEL);
        wv_s = signed'({{2{wv[15]}}, wv});
        if (wr) begin
          if (wv_s >= ACL_SHI_MIN && wv_s <= ACL_SHI_MAX) begin
            st_next.scale_hi = wv; // see R02
          end else begin
            refused = 1'b1; // see R02
          end
        end
      end
      ACL_OFS_FAULT: begin
        rd = {16'h0000, st_reg.fault_val};
        if (wr) st_next.fault_val = wmerge(st_reg.fault_val, I_WB_DAT, I_WB_SEL);
      end
      ACL_OFS_IDLE: begin
        rd = {16'h0000, st_reg.idle_val};
        if (wr) st_next.idle_val = wmerge(st_reg.idle_val, I_WB_DAT, I_WB_SEL);
      end
      ACL_OFS_SETVAL: begin
        rd = {16'h0000, st_reg.set_val};
        if (wr) st_next.set_val = wmerge(st_reg.set_val, I_WB_DAT, I_WB_SEL);
      end
      ACL_OFS_STATUS: begin
        rd = {29'h0000000, st_reg.status};
        if (wr && I_WB_SEL[0]) clr = I_WB_DAT[ACL_ST_W-1:0];
      end
      ACL_OFS_MASK: begin
        rd = {29'h0000000, st_reg.mask};
        if (wr && I_WB_SEL[0]) st_next.mask = I_WB_DAT[ACL_ST_W-1:0];
      end
      ACL_OFS_OUT: begin
        rd = {16'h0000, st_reg.out};
      end
      default: begin
        // Unmapped: acknowledged, reads zero, writes dropped
        rd = 32'h0000_0000;
      end
    endcase
    if (req) begin
      st_next.rdat = rd;
    end

    // A refused scale limit write counts as a range event as well
    evt = '0;
    evt[ACL_SB_USR_LO] = usr_lo_err;
    evt[ACL_SB_SC_LO]  = sc_lo_err;
    evt[ACL_SB_CLAMP]  = (~hold & (under | over)) | refused; // see R10
    // Setting beats clearing so no event is lost
    st_next.status = (st_reg.status & ~clr) | evt;
    st_next.irq    = |(st_next.status & st_next.mask);
    st_next.err    = {sc_lo_err, usr_lo_err};

    if (!hold) begin
      st_next.out = conv;
    end
  end

  // ===========================================================================
  // Registers
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      st_reg           <= '0;
      st_reg.ctrl      <= ACL_CTRL_RST;
      st_reg.user_lo   <= ACL_USER_LO_RST;
      st_reg.scale_lo  <= ACL_SCALE_LO_RST;
      st_reg.scale_hi  <= ACL_SCALE_HI_RST;
      st_reg.fault_val <= ACL_VAL_RST;
      st_reg.idle_val  <= ACL_VAL_RST;
      st_reg.set_val   <= ACL_VAL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ===========================================================================
  // Outputs
  assign O_WB_ACK    = st_reg.ack;
  assign O_WB_DAT    = st_reg.rdat;
  assign O_IRQ       = st_reg.irq;
  assign O_OUT_VALUE = st_reg.out;
  assign O_LIMIT_ERR = st_reg.err;

endmodule

/* tb/acl_assertions.sv */
// Port-level checks for the analogue channel block
`timescale 1ns/100ps
module acl_assertions
  import acl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              I_CLOCK,      // Clock
  input wire logic              I_RST,        // Reset
  input wire logic              I_WB_CYC,     // Cycle
  input wire logic              I_WB_STB,     // Strobe
  input wire logic              I_WB_WE,      // Write
  input wire logic [ADDR_W-1:0] I_WB_ADR,     // Address
  input wire logic [3:0]        I_WB_SEL,     // Lanes
  input wire logic [31:0]       I_WB_DAT,     // Write data
  input wire logic              I_COMM_FAULT, // Fault
  input wire logic              I_COMM_IDLE,  // Idle
  input wire logic              O_WB_ACK,     // Ack
  input wire logic [15:0]       O_OUT_VALUE,  // Output
  input wire logic [1:0]        O_LIMIT_ERR   // Errors
);
  // ==========================================================================
  // Control shadow: the mode is not visible at the ports
  logic [9:0] ctrl_reg;
  logic       ctrl_wr;
  assign ctrl_wr = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK && I_WB_ADR[7:0] == ACL_OFS_CTRL;
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg <= ACL_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= {I_WB_SEL[1] ? I_WB_DAT[9:8] : ctrl_reg[9:8], I_WB_SEL[0] ? I_WB_DAT[7:0] : ctrl_reg[7:0]};
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held too long");
  a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("no ack");
  a_ack_cause: assert property (!(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK) else $error("ack unasked");
  a_out_span: assert property (O_OUT_VALUE <= 16'h0834) else $error("output above span");
  a_fault_hold: assert property (I_COMM_FAULT && !(ctrl_reg[ACL_CB_FAULT_SUB] && ctrl_reg[ACL_CB_PRIO_SW])
    |=> $stable(O_OUT_VALUE)) else $error("output moved during fault");
  a_idle_hold: assert property (!I_COMM_FAULT && I_COMM_IDLE && !ctrl_reg[ACL_CB_IDLE_SUB]
    |=> $stable(O_OUT_VALUE)) else $error("output moved during idle");
  a_user_off: assert property (!ctrl_reg[ACL_CB_LO_CHK] |=> !O_LIMIT_ERR[0]) else $error("user error");
  a_scale_off: assert property (!(ctrl_reg[ACL_CB_SC_CHK] && ctrl_reg[4:3] == ACL_FMT_SCALED)
    |=> !O_LIMIT_ERR[1]) else $error("scale error while off");
endmodule

/* tb/acl_host_model.sv */
// Host controller model: link state and measured value
`timescale 1ns/100ps
module acl_host_model (
  input  wire logic        i_clk,      // Clock
  input  wire logic        i_rst,      // Reset
  input  wire logic [1:0]  i_state,    // [0] fault, [1] idle
  input  wire logic [15:0] i_value,    // Requested value
  output logic             o_fault,    // Comm fault
  output logic             o_idle,     // Comm idle
  output logic [15:0]      o_in_value  // Measured value
);
  // ==========================================================================
  // Host changes its lines only just after an edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fault    <= 1'b0;
      o_idle     <= 1'b0;
      o_in_value <= 16'h0000;
    end else begin
      o_fault    <= i_state[0];
      o_idle     <= i_state[1];
      o_in_value <= i_value;
    end
  end
endmodule

/* tb/acl_channel_bench.sv */
// Self-checking bench for the analogue channel block
`timescale 1ns/100ps
module acl_channel_bench
  import acl_pkg::*;
;
  typedef struct {logic [9:0] ctrl; logic [15:0] set; logic [15:0] out;} acl_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [1:0]  link_req = 2'h0;
  logic [15:0] in_req = 16'h0000;
  logic        fault, idle, ack, irq;
  logic [15:0] in_val, out_val;
  logic [31:0] dat_o;
  logic [1:0]  lim;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  acl_row_s    rows [12] = '{'{10'h000, 16'h01f4, 16'h01f4}, '{10'h000, 16'h044c, 16'h041a},
    '{10'h020, 16'h0258, 16'h020d}, '{10'h040, 16'h0032, 16'h004b}, '{10'h060, 16'h07d0, 16'h07d0},
    '{10'h080, 16'h0064, 16'h012c}, '{10'h058, 16'h0fa0, 16'h0190}, '{10'h058, 16'h8064, 16'h004b},
    '{10'h098, 16'h1388, 16'h07d0}, '{10'h018, 16'h0bb8, 16'h01f4},
    '{10'h008, 16'h01f4, 16'h01f4}, '{10'h010, 16'h0514, 16'h041a}};

  always #2.5 clk = ~clk;

  acl_host_model i_acl_host_model (.i_clk(clk), .i_rst(rst), .i_state(link_req), .i_value(in_req),
    .o_fault(fault), .o_idle(idle), .o_in_value(in_val));

  acl_channel i_acl_channel (.I_CLOCK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .I_COMM_FAULT(fault), .I_COMM_IDLE(idle),
    .I_IN_VALUE(in_val), .O_WB_ACK(ack), .O_WB_DAT(dat_o), .O_IRQ(irq), .O_OUT_VALUE(out_val),
    .O_LIMIT_ERR(lim));

  // ==========================================================================
  // Tasks
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One classic cycle; the wait is cut short only by the timeout
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      $display("MISMATCH timeout expected finish seen hang");
      errors++;
      close_out();
    end
  end

  // ==========================================================================
  // Sequence
  initial begin
    tick(5);
    rst <= 1'b0;
    wr(ACL_OFS_SCALE_LO, 32'h03e8);
    wr(ACL_OFS_SCALE_HI, 32'h1388);
    foreach (rows[i]) begin
      wr(ACL_OFS_CTRL, {22'h0, rows[i].ctrl});
      wr(ACL_OFS_SETVAL, {16'h0, rows[i].set});
      tick(2);
      chk("out_value", {16'h0, rows[i].out}, {16'h0, out_val});
      rdchk("out_reg", ACL_OFS_OUT, {16'h0, rows[i].out});
    end
    $display("Test rows done");
    // Fault substitution without software priority must hold
    wr(ACL_OFS_CTRL, 32'h0002);
    wr(ACL_OFS_FAULT, 32'h012c);
    wr(ACL_OFS_IDLE, 32'h02bc);
    wr(ACL_OFS_SETVAL, 32'h01f4);
    link_req <= 2'h1;
    wr(ACL_OFS_SETVAL, 32'h0384);
    tick(3);
    chk("fault_hold", 32'h01f4, {16'h0, out_val});
    wr(ACL_OFS_CTRL, 32'h0106);
    tick(2);
    chk("fault_value", 32'h012c, {16'h0, out_val});
    link_req <= 2'h3;
    tick(3);
    chk("fault_over_idle", 32'h012c, {16'h0, out_val});
    link_req <= 2'h2;
    tick(3);
    chk("idle_value", 32'h02bc, {16'h0, out_val});
    wr(ACL_OFS_CTRL, 32'h0102);
    tick(2);
    chk("idle_hold", 32'h02bc, {16'h0, out_val});
    link_req <= 2'h0;
    tick(3);
    chk("link_ok", 32'h0384, {16'h0, out_val});
    // Software priority alone, with substitution off, must still hold
    wr(ACL_OFS_CTRL, 32'h0100);
    link_req <= 2'h1;
    wr(ACL_OFS_SETVAL, 32'h01f4);
    tick(3);
    chk("prio_no_sub", 32'h0384, {16'h0, out_val});
    link_req <= 2'h0;
    $display("Test substitution done");
    // User lower limit, mask and clear
    wr(ACL_OFS_CTRL, 32'h0001);
    wr(ACL_OFS_USER_LO, 32'h0190);
    in_req <= 16'h012c;
    tick(3);
    chk("user_err", 32'h1, {31'h0, lim[0]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(ACL_OFS_MASK, 32'h0001);
    tick(2);
    chk("irq_on", 32'h1, {31'h0, irq});
    in_req <= 16'h01c2;
    wr(ACL_OFS_STATUS, 32'h0007);
    tick(2);
    chk("irq_clear", 32'h0, {31'h0, irq});
    chk("user_ok", 32'h0, {31'h0, lim[0]});
    $display("Test user limit done");
    // Scale lower limit, scale bounds and extreme scaled values
    wr(ACL_OFS_CTRL, 32'h0218);
    in_req <= 16'h01f4;
    tick(3);
    chk("scale_err", 32'h2, {30'h0, lim});
    wr(ACL_OFS_SCALE_LO, 32'h7fff);
    rdchk("slo_refused", ACL_OFS_SCALE_LO, 32'h03e8);
    rdchk("status", ACL_OFS_STATUS, 32'h0006);
    wr(ACL_OFS_SCALE_LO, 32'h8001);
    rdchk("slo_min", ACL_OFS_SCALE_LO, 32'h8001);
    wr(ACL_OFS_SCALE_HI, 32'h7fff);
    wr(ACL_OFS_SCALE_HI, 32'h8001);
    rdchk("shi_refused", ACL_OFS_SCALE_HI, 32'h7fff);
    wr(ACL_OFS_SETVAL, 32'h7fff);
    tick(2);
    chk("scaled_max", 32'h03e8, {16'h0, out_val});
    wr(ACL_OFS_SETVAL, 32'hffff);
    tick(2);
    chk("scaled_min", 32'h0, {16'h0, out_val});
    $display("Test scaling done");
    // Reset in mid-run and an unmapped place
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rdchk("ctrl_rst", ACL_OFS_CTRL, 32'h0);
    rdchk("shi_rst", ACL_OFS_SCALE_HI, 32'h03e8);
    rdchk("slo_rst", ACL_OFS_SCALE_LO, 32'h0);
    wr(8'h30, 32'h1234);
    rdchk("unmapped", 8'h30, 32'h0);
    chk("out_rst", 32'h0, {16'h0, out_val});
    $display("Test reset done");
    close_out();
  end
endmodule

bind acl_channel acl_assertions #(.ADDR_W(ADDR_W)) i_acl_assertions (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
  .I_WB_DAT(I_WB_DAT), .I_COMM_FAULT(I_COMM_FAULT), .I_COMM_IDLE(I_COMM_IDLE), .O_WB_ACK(O_WB_ACK),
  .O_OUT_VALUE(O_OUT_VALUE), .O_LIMIT_ERR(O_LIMIT_ERR));
